/* src/dma_cfg_pkg.sv */
// Shared constants and types for the per-channel DMA configuration block
package dma_cfg_pkg;
    // Register addresses on the special-function register port
    localparam logic [7:0] ADDR_CHANNEL_SELECT     = 8'hd1;
    localparam logic [7:0] ADDR_CHANNEL_CONFIG     = 8'hc9;
    localparam logic [7:0] ADDR_BASE_ADDRESS_LOW   = 8'hca;
    localparam logic [7:0] ADDR_BASE_ADDRESS_HIGH  = 8'hcb;
    localparam logic [7:0] ADDR_OFFSET_LOW         = 8'hcc;
    localparam logic [7:0] ADDR_OFFSET_HIGH        = 8'hcd;
    localparam logic [7:0] ADDR_SIZE_LOW           = 8'hce;
    localparam logic [7:0] ADDR_SIZE_HIGH          = 8'hcf;

    // Channel counts and codes
    localparam int         NUM_CHANNELS            = 7;
    localparam logic [2:0] CHANNEL_INVALID         = 3'h7;

    // Field positions of channel_config
    localparam int         POS_FULL_EN             = 7;
    localparam int         POS_MID_EN              = 6;
    localparam int         POS_STALL               = 5;
    localparam int         POS_ENDIAN              = 4;

    // Reset values
    localparam logic [7:0] RESET_CONFIG            = 8'h00;
    localparam logic [7:0] RESET_BYTE              = 8'h00;
    localparam logic [2:0] RESET_SELECT            = 3'h0;

    // Indices of the per-channel write strobes
    localparam int         WR_CFG                  = 0;
    localparam int         WR_BASE_LO              = 1;
    localparam int         WR_BASE_HI              = 2;
    localparam int         WR_OFS_LO               = 3;
    localparam int         WR_OFS_HI               = 4;
    localparam int         WR_SIZE_LO              = 5;
    localparam int         WR_SIZE_HI              = 6;

    // Transfer functions
    typedef enum logic [3:0] {
        FN_RAM_TO_ENCODER  = 4'h0,
        FN_ENCODER_TO_RAM  = 4'h1,
        FN_RAM_TO_CRC      = 4'h2,
        FN_RAM_TO_SPI      = 4'h3,
        FN_SPI_TO_RAM      = 4'h4,
        FN_RAM_TO_KEY      = 4'h5,
        FN_RAM_TO_BLOCK    = 4'h6,
        FN_RAM_TO_XOR      = 4'h7,
        FN_CIPHER_TO_RAM   = 4'h8
    } transfer_function_t;
    localparam logic [3:0] FN_LAST_VALID           = 4'h8;

    // Layout of channel_config, high bit first
    typedef struct packed {
        logic       full_length_irq_enable;
        logic       mid_point_irq_enable;
        logic       stall;
        logic       big_endian;
        logic [3:0] transfer_function_select;
    } chan_cfg_t;

    // Everything one channel keeps
    typedef struct packed {
        chan_cfg_t   cfg;
        logic [11:0] base;
        logic [9:0]  offset;
        logic [9:0]  size;
    } chan_state_t;
endpackage

/* src/dma_chan_regs.sv */
// One channel's configuration, base, offset and size storage
`timescale 1ns/1ps
module dma_chan_regs (
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic [6:0]               wsel_i,
    input  wire logic [7:0]               wdata_i,
    input  wire logic                     step_i,
    output dma_cfg_pkg::chan_state_t      state_o
);
    dma_cfg_pkg::chan_cfg_t cfg;
    logic [3:0]             base_high_bits;
    logic [7:0]             base_low_bits;
    logic [9:0]             address_offset;
    logic [9:0]             transfer_size;
    logic [9:0]             next_offset;

    // Software write beats the step so a reconfigured offset is never lost
    always_comb begin
        next_offset = address_offset;
        if (wsel_i[dma_cfg_pkg::WR_OFS_LO]) begin
            next_offset = {address_offset[9:8], wdata_i};
        end else if (wsel_i[dma_cfg_pkg::WR_OFS_HI]) begin
            next_offset = {wdata_i[1:0], address_offset[7:0]};
        end else if (step_i) begin
            next_offset = address_offset + 10'h001;
        end
    end

    // Stall bit changes only through a software write, never by itself
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg            <= dma_cfg_pkg::RESET_CONFIG;
            base_high_bits <= dma_cfg_pkg::RESET_BYTE[3:0];
            base_low_bits  <= dma_cfg_pkg::RESET_BYTE;
            address_offset <= {2'h0, dma_cfg_pkg::RESET_BYTE};
            transfer_size  <= {2'h0, dma_cfg_pkg::RESET_BYTE};
        end else begin
            if (wsel_i[dma_cfg_pkg::WR_CFG]) begin
                cfg <= wdata_i;
            end
            if (wsel_i[dma_cfg_pkg::WR_BASE_LO]) begin
                base_low_bits <= wdata_i;
            end
            if (wsel_i[dma_cfg_pkg::WR_BASE_HI]) begin
                base_high_bits <= wdata_i[3:0];
            end
            if (wsel_i[dma_cfg_pkg::WR_SIZE_LO]) begin
                transfer_size <= {transfer_size[9:8], wdata_i};
            end
            if (wsel_i[dma_cfg_pkg::WR_SIZE_HI]) begin
                transfer_size <= {wdata_i[1:0], transfer_size[7:0]};
            end
            address_offset <= next_offset;
        end
    end

    // Base address is the high nibble over the low byte
    assign state_o = {cfg, base_high_bits, base_low_bits, address_offset, transfer_size};
endmodule // dma_chan_regs

/* src/dma_channel_config.sv */
// Seven-channel DMA configuration with indirect register access and byte stepping
// Notes on behaviour
// - Indirect registers reach only the channel named by channel_select.
// - Config bit 7 enables the channel's full-length interrupt.
// - Config bit 6 enables the channel's mid-point interrupt.
// - Config bit 5 set holds the channel stalled; no bytes move.
// - Stall is never cleared by hardware; software writes zero to resume.
// - Config bit 4 picks little or big endian for multi-byte transfers.
// - Single-byte transfer functions ignore the byte-order bit.
// - Four-bit function field selects one of nine transfers, codes 0 to 8.
// - Base address is twelve bits: high nibble and low byte.
// - Upper four bits of base high read zero; writes ignored.
// - Offset increments after each byte; RAM address is base plus offset.
// - Offset reaching transfer size raises the full-length interrupt.
// - Select codes 0 to 6 choose channels; code 7 is invalid.
`timescale 1ns/1ps
module dma_channel_config (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    input  wire logic        xfer_req_i,
    input  wire logic [2:0]  xfer_chan_i,
    output logic             xfer_grant_o,
    output logic      [11:0] ram_addr_o,
    output logic      [3:0]  xfer_func_o,
    output logic             big_endian_o,
    output logic      [6:0]  full_irq_o,
    output logic      [6:0]  mid_irq_o
);
    localparam int NCH = dma_cfg_pkg::NUM_CHANNELS;

    dma_cfg_pkg::chan_state_t st [NCH];
    logic [2:0]               channel_select;
    logic                     sel_valid;
    logic [6:0]               field_wsel;
    logic [6:0]               step;
    logic                     xfer_chan_valid;
    dma_cfg_pkg::chan_state_t cur;
    logic                     func_valid;
    logic                     func_multi_byte;
    logic                     eligible;
    logic [9:0]               offset_plus;
    logic [9:0]               half_size;
    logic                     hit_full;
    logic                     hit_mid;
    dma_cfg_pkg::chan_state_t sel_st;
    logic [7:0]               read_mux;
    logic                     next_big_endian;

    // Field decode; an invalid select blocks every indirect write
    assign sel_valid  = (channel_select != dma_cfg_pkg::CHANNEL_INVALID);
    assign field_wsel[dma_cfg_pkg::WR_CFG]     = sfr_wr_i && sfr_addr_i == dma_cfg_pkg::ADDR_CHANNEL_CONFIG;
    assign field_wsel[dma_cfg_pkg::WR_BASE_LO] = sfr_wr_i && sfr_addr_i == dma_cfg_pkg::ADDR_BASE_ADDRESS_LOW;
    assign field_wsel[dma_cfg_pkg::WR_BASE_HI] = sfr_wr_i && sfr_addr_i == dma_cfg_pkg::ADDR_BASE_ADDRESS_HIGH;
    assign field_wsel[dma_cfg_pkg::WR_OFS_LO]  = sfr_wr_i && sfr_addr_i == dma_cfg_pkg::ADDR_OFFSET_LOW;
    assign field_wsel[dma_cfg_pkg::WR_OFS_HI]  = sfr_wr_i && sfr_addr_i == dma_cfg_pkg::ADDR_OFFSET_HIGH;
    assign field_wsel[dma_cfg_pkg::WR_SIZE_LO] = sfr_wr_i && sfr_addr_i == dma_cfg_pkg::ADDR_SIZE_LOW;
    assign field_wsel[dma_cfg_pkg::WR_SIZE_HI] = sfr_wr_i && sfr_addr_i == dma_cfg_pkg::ADDR_SIZE_HIGH;

    // The requesting channel's view
    assign xfer_chan_valid = (xfer_chan_i != dma_cfg_pkg::CHANNEL_INVALID);
    assign cur             = xfer_chan_valid ? st[xfer_chan_i] : '0;
    assign func_valid      = (cur.cfg.transfer_function_select <= dma_cfg_pkg::FN_LAST_VALID);
    assign func_multi_byte = (cur.cfg.transfer_function_select == dma_cfg_pkg::FN_RAM_TO_ENCODER) ||
                             (cur.cfg.transfer_function_select == dma_cfg_pkg::FN_ENCODER_TO_RAM);
    // A stalled, finished or undefined channel moves nothing
    assign eligible        = xfer_req_i && xfer_chan_valid && !cur.cfg.stall && func_valid &&
                             (cur.offset < cur.size);
    assign offset_plus     = cur.offset + 10'h001;
    assign half_size       = {1'b0, cur.size[9:1]};
    assign hit_full        = eligible && (offset_plus == cur.size);
    assign hit_mid         = eligible && (half_size != 10'h000) && (offset_plus == half_size);
    // Byte order only matters for the three-byte encoder transfers
    assign next_big_endian = func_multi_byte && cur.cfg.big_endian;

    // One register set per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            assign step[g] = eligible && (xfer_chan_i == 3'(g));
            dma_chan_regs u_regs (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .wsel_i  ((sel_valid && channel_select == 3'(g)) ? field_wsel : 7'h00),
                .wdata_i (sfr_wdata_i),
                .step_i  (step[g]),
                .state_o (st[g])
            );
        end
    endgenerate

    // Read path: selected channel only, unused bits and unmapped addresses read zero
    assign sel_st = sel_valid ? st[channel_select] : '0;
    always_comb begin
        case (sfr_addr_i)
            dma_cfg_pkg::ADDR_CHANNEL_SELECT:    read_mux = {5'h00, channel_select};
            dma_cfg_pkg::ADDR_CHANNEL_CONFIG:    read_mux = sel_st.cfg;
            dma_cfg_pkg::ADDR_BASE_ADDRESS_LOW:  read_mux = sel_st.base[7:0];
            dma_cfg_pkg::ADDR_BASE_ADDRESS_HIGH: read_mux = {4'h0, sel_st.base[11:8]};
            dma_cfg_pkg::ADDR_OFFSET_LOW:        read_mux = sel_st.offset[7:0];
            dma_cfg_pkg::ADDR_OFFSET_HIGH:       read_mux = {6'h00, sel_st.offset[9:8]};
            dma_cfg_pkg::ADDR_SIZE_LOW:          read_mux = sel_st.size[7:0];
            dma_cfg_pkg::ADDR_SIZE_HIGH:         read_mux = {6'h00, sel_st.size[9:8]};
            default:                             read_mux = 8'h00;
        endcase
    end

    // Select register and registered read data
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            channel_select <= dma_cfg_pkg::RESET_SELECT;
            sfr_rdata_o    <= dma_cfg_pkg::RESET_BYTE;
        end else begin
            if (sfr_wr_i && sfr_addr_i == dma_cfg_pkg::ADDR_CHANNEL_SELECT) begin
                channel_select <= sfr_wdata_i[2:0];
            end
            if (sfr_rd_i) begin
                sfr_rdata_o <= read_mux;
            end
        end
    end

    // Byte grant, address and interrupt pulses, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            xfer_grant_o <= 1'b0;
            ram_addr_o   <= 12'h000;
            xfer_func_o  <= 4'h0;
            big_endian_o <= 1'b0;
            full_irq_o   <= 7'h00;
            mid_irq_o    <= 7'h00;
        end else begin
            xfer_grant_o <= eligible;
            if (eligible) begin
                ram_addr_o   <= cur.base + {2'h0, cur.offset};
                xfer_func_o  <= cur.cfg.transfer_function_select;
                big_endian_o <= next_big_endian;
            end
            full_irq_o <= (hit_full && cur.cfg.full_length_irq_enable) ? step : 7'h00;
            mid_irq_o  <= (hit_mid && cur.cfg.mid_point_irq_enable) ? step : 7'h00;
        end
    end

    // Helpers for the checks below
    logic [11:0] exp_addr;
    logic [2:0]  last_chan;
    logic        last_write_ofs;
    assign exp_addr = cur.base + {2'h0, cur.offset};
    always_ff @(posedge clk_i) begin
        last_chan      <= xfer_chan_i;
        last_write_ofs <= |field_wsel[dma_cfg_pkg::WR_OFS_HI:dma_cfg_pkg::WR_OFS_LO];
    end

    sequence s_grant_taken;
        eligible ##1 xfer_grant_o;
    endsequence

    property p_stall_blocks;
        @(posedge clk_i) disable iff (!rst_n_i) (xfer_req_i && cur.cfg.stall) |=> !xfer_grant_o;
    endproperty
    a_stall_blocks: assert property (p_stall_blocks) else $error("stalled channel was granted");

    property p_stall_kept;
        @(posedge clk_i) disable iff (!rst_n_i)
            (st[2].cfg.stall && !(field_wsel[dma_cfg_pkg::WR_CFG] && channel_select == 3'h2)) |=> st[2].cfg.stall;
    endproperty
    a_stall_kept: assert property (p_stall_kept) else $error("stall cleared without a write");

    property p_addr;
        logic [11:0] a;
        @(posedge clk_i) disable iff (!rst_n_i) (eligible, a = exp_addr) |=> (xfer_grant_o && ram_addr_o == a);
    endproperty
    a_addr: assert property (p_addr) else $error("ram address is not base plus offset");

    property p_offset_step;
        @(posedge clk_i) disable iff (!rst_n_i)
            s_grant_taken |-> (last_write_ofs || st[last_chan].offset == $past(offset_plus));
    endproperty
    a_offset_step: assert property (p_offset_step) else $error("offset did not advance by one");

    property p_full_irq;
        @(posedge clk_i) disable iff (!rst_n_i)
            (hit_full && cur.cfg.full_length_irq_enable) |=> full_irq_o[last_chan] ##1 !full_irq_o[last_chan];
    endproperty
    a_full_irq: assert property (p_full_irq) else $error("full-length pulse missing or long");

    property p_full_gate;
        @(posedge clk_i) disable iff (!rst_n_i)
            (hit_full && !cur.cfg.full_length_irq_enable) |=> full_irq_o == 7'h00;
    endproperty
    a_full_gate: assert property (p_full_gate) else $error("disabled full-length interrupt fired");

    property p_mid_gate;
        @(posedge clk_i) disable iff (!rst_n_i)
            (hit_mid && !cur.cfg.mid_point_irq_enable) |=> mid_irq_o == 7'h00;
    endproperty
    a_mid_gate: assert property (p_mid_gate) else $error("disabled mid-point interrupt fired");

    property p_mid_irq;
        @(posedge clk_i) disable iff (!rst_n_i)
            (hit_mid && cur.cfg.mid_point_irq_enable) |=> mid_irq_o[last_chan];
    endproperty
    a_mid_irq: assert property (p_mid_irq) else $error("mid-point pulse missing");

    property p_func_invalid;
        @(posedge clk_i) disable iff (!rst_n_i) (xfer_req_i && !func_valid) |=> !xfer_grant_o;
    endproperty
    a_func_invalid: assert property (p_func_invalid) else $error("undefined function moved a byte");

    property p_single_byte_order;
        @(posedge clk_i) disable iff (!rst_n_i)
            (xfer_grant_o && xfer_func_o != 4'h0 && xfer_func_o != 4'h1) |-> !big_endian_o;
    endproperty
    a_single_byte_order: assert property (p_single_byte_order) else $error("byte order on single byte");

    property p_func_out;
        logic [3:0] f;
        @(posedge clk_i) disable iff (!rst_n_i)
            (eligible, f = cur.cfg.transfer_function_select) |=> xfer_func_o == f;
    endproperty
    a_func_out: assert property (p_func_out) else $error("function output does not follow field");

    property p_base_high_read;
        @(posedge clk_i) disable iff (!rst_n_i)
            (sfr_rd_i && sfr_addr_i == dma_cfg_pkg::ADDR_BASE_ADDRESS_HIGH) |=> sfr_rdata_o[7:4] == 4'h0;
    endproperty
    a_base_high_read: assert property (p_base_high_read) else $error("base high upper bits nonzero");

    property p_invalid_select;
        @(posedge clk_i) disable iff (!rst_n_i)
            (sfr_rd_i && !sel_valid && sfr_addr_i == dma_cfg_pkg::ADDR_CHANNEL_CONFIG) |=> sfr_rdata_o == 8'h00;
    endproperty
    a_invalid_select: assert property (p_invalid_select) else $error("invalid select reached a channel");
endmodule // dma_channel_config

/* sim/byte_mover_model.sv */
// Byte mover standing on the far side of the stepping port
`timescale 1ns/1ps
module byte_mover_model (
    input  wire logic       clk_i,
    input  wire logic       load_i,
    input  wire logic [2:0] chan_i,
    input  wire logic [7:0] count_i,
    output logic            req_o,
    output logic [2:0]      chan_o
);
    logic [7:0] left;
    logic       load_seen;

    // One request per cycle, changed just after the edge; idle channel steps by three each cycle so a stale value is never held
    // One process owns the outputs from time zero, so they never have two drivers
    initial begin
        left   = 8'h00;
        req_o  = 1'b0;
        chan_o = 3'h0;
        forever begin
            @(posedge clk_i);
            load_seen = load_i;
            #1;
            if (load_seen) begin
                left = count_i;
            end
            if (left != 8'h00) begin
                req_o  = 1'b1;
                chan_o = chan_i;
                left   = left - 8'h01;
            end else begin
                req_o  = 1'b0;
                chan_o = chan_o + 3'h3;
            end
        end
    end
endmodule // byte_mover_model

/* sim/dma_channel_config_tb_top.sv */
// Self-checking bench for the DMA channel configuration block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module dma_channel_config_tb_top;
    logic        clk_i, rst_n_i, sfr_wr_i, sfr_rd_i, xfer_req_i, xfer_grant_o, big_endian_o, mv_load;
    logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, mv_n;
    logic [2:0]  xfer_chan_i, mv_ch;
    logic [11:0] ram_addr_o;
    logic [3:0]  xfer_func_o;
    logic [6:0]  full_irq_o, mid_irq_o;
    logic [7:0]  cfg [8];
    logic [11:0] base [8];
    logic [9:0]  size [8];
    logic [31:0] seed;
    logic [7:0]  c;
    logic [9:0]  s;
    int          n_mismatch, cmp_count;

    dma_channel_config dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .xfer_req_i(xfer_req_i),
        .xfer_chan_i(xfer_chan_i), .xfer_grant_o(xfer_grant_o), .ram_addr_o(ram_addr_o), .xfer_func_o(xfer_func_o),
        .big_endian_o(big_endian_o), .full_irq_o(full_irq_o), .mid_irq_o(mid_irq_o));

    byte_mover_model mover (.clk_i(clk_i), .load_i(mv_load), .chan_i(mv_ch), .count_i(mv_n),
        .req_o(xfer_req_i), .chan_o(xfer_chan_i));

    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Thirty-two steps per call so neighbouring draws are unrelated
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        for (int i = 0; i < 32; i++) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
        return x;
    endfunction

    // Only the encoder functions carry more than one byte
    function automatic logic exp_endian(input logic [7:0] cf);
        return (cf[3:0] < 4'h2) ? cf[4] : 1'b0;
    endfunction

    // Idle edge after each write so the next call never re-raises the strobe in the same step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i  = a;
        sfr_wdata_i = d;
        sfr_wr_i    = 1'b1;
        @(posedge clk_i);
        #1;
        sfr_wr_i = 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    // Idle edge before returning keeps strobes from being raised twice in one step
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        sfr_addr_i = a;
        sfr_rd_i   = 1'b1;
        @(posedge clk_i);
        #1;
        sfr_rd_i = 1'b0;
        `CHK(nm, e, sfr_rdata_o)
        @(posedge clk_i);
        #1;
    endtask

    task automatic cfg_chan(input logic [2:0] ch, input logic [7:0] cv, input logic [9:0] sv);
        wr(8'hd1, {5'h00, ch});
        wr(8'hc9, cv);
        wr(8'hcc, 8'h00);
        wr(8'hcd, 8'h00);
        wr(8'hce, sv[7:0]);
        wr(8'hcf, {6'h00, sv[9:8]});
        @(posedge clk_i);
        #1;
        cfg[ch]  = cv;
        size[ch] = sv;
    endtask

    // Ask for n bytes and check every grant, address and interrupt pulse
    task automatic xfer(input logic [2:0] ch, input int n, input int exp_g);
        int   g;
        logic hf, hm;
        g       = 0;
        mv_ch   = ch;
        mv_n    = 8'(n);
        mv_load = 1'b1;
        @(posedge clk_i);
        #1;
        mv_load = 1'b0;
        repeat (n + 4) begin
            @(posedge clk_i);
            #1;
            hf = 1'b0;
            hm = 1'b0;
            if (xfer_grant_o === 1'b1) begin
                `CHK("ram_addr", base[ch] + 12'(g), ram_addr_o)
                `CHK("func", cfg[ch][3:0], xfer_func_o)
                `CHK("endian", exp_endian(cfg[ch]), big_endian_o)
                g++;
                hf = (g == int'(size[ch])) && cfg[ch][7];
                hm = (size[ch] >= 10'h2) && (g == int'(size[ch] / 10'h2)) && cfg[ch][6];
            end
            `CHK("full_irq", hf ? (7'h01 << ch) : 7'h00, full_irq_o)
            `CHK("mid_irq", hm ? (7'h01 << ch) : 7'h00, mid_irq_o)
        end
        `CHK("grants", exp_g, g)
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the several hundred cycles the sequence needs
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        final_report();
    end

    initial begin
        {rst_n_i, sfr_wr_i, sfr_rd_i, mv_load, sfr_addr_i, sfr_wdata_i, mv_n, mv_ch} = '0;
        n_mismatch = 0;
        cmp_count  = 0;
        seed       = 32'hdf95;
        for (int i = 0; i < 8; i++) begin
            cfg[i]  = 8'h00;
            base[i] = 12'h000;
            size[i] = 10'h000;
        end
        repeat (10) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        // Reset values, unmapped space and select field width
        for (int ch = 0; ch < 7; ch++) begin
            wr(8'hd1, 8'(ch));
            rd(8'hc9, 8'h00, "cfg_reset");
            rd(8'hca, 8'h00, "base_lo_reset");
            rd(8'hcb, 8'h00, "base_hi_reset");
        end
        rd(8'h00, 8'h00, "unmapped");
        wr(8'hd1, 8'hfa);
        rd(8'hd1, 8'h02, "select");
        // Random setup per channel; fixed corners on channels 0, 5 and 6
        for (int ch = 0; ch < 7; ch++) begin
            seed = lfsr(seed);
            c    = {seed[7:6], 1'b0, seed[4], 4'(seed[11:8] % 4'h9)};
            s    = 10'(seed[18:16] % 3'h6) + 10'h001;
            if (ch == 0) begin
                c = 8'hd0;
                s = 10'h005;
            end
            // Both interrupts disabled, so the gating checks see a real hit
            if (ch == 5) begin
                c = 8'h03;
                s = 10'h004;
            end
            if (ch == 6) begin
                c = 8'hd8;
                s = 10'h001;
            end
            cfg_chan(3'(ch), c, s);
            wr(8'hca, seed[31:24]);
            wr(8'hcb, seed[23:16]);
            base[ch] = {seed[19:16], seed[31:24]};
        end
        for (int ch = 0; ch < 7; ch++) begin
            wr(8'hd1, 8'(ch));
            rd(8'hc9, cfg[ch], "cfg");
            rd(8'hca, base[ch][7:0], "base_lo");
            rd(8'hcb, {4'h0, base[ch][11:8]}, "base_hi");
        end
        // Invalid select drops writes and reads zero
        wr(8'hd1, 8'h07);
        wr(8'hc9, 8'hff);
        rd(8'hc9, 8'h00, "cfg_sel7");
        wr(8'hd1, 8'h00);
        rd(8'hc9, cfg[0], "cfg_kept");
        // Full runs, with one refused request past the end
        for (int ch = 0; ch < 7; ch++) begin
            xfer(3'(ch), int'(size[ch]) + 1, int'(size[ch]));
            wr(8'hd1, 8'(ch));
            rd(8'hcc, size[ch][7:0], "offset");
        end
        xfer(3'h7, 3, 0);
        // Stall holds, survives, and software clearing resumes
        cfg_chan(3'h2, cfg[2] | 8'h20, size[2]);
        xfer(3'h2, 3, 0);
        rd(8'hc9, cfg[2], "stall_kept");
        cfg_chan(3'h2, cfg[2] & 8'hdf, size[2]);
        xfer(3'h2, int'(size[2]) + 1, int'(size[2]));
        // Undefined function codes move nothing
        for (int f = 9; f < 16; f++) begin
            cfg_chan(3'h3, {4'hc, 4'(f)}, 10'h004);
            xfer(3'h3, 2, 0);
        end
        final_report();
    end
endmodule // dma_channel_config_tb_top
